// ---- bench/serial_flash_program_erase_tb.sv ----
// self-checking bench of the program and erase sequencer
`timescale 1ns/1ps
`default_nettype none
// ========
// bench top
module serial_flash_program_erase_tb;
  import sfpe_pkg::*;
  localparam int TPP = 20;
  localparam int TSE = 30;
  logic       clk, srst, qen, a4, sck, cs_n, busy, latch, we, ereq;
  logic [4:0] bp, elog2;
  logic [3:0] hd, din, dout, oe;
  logic [7:0] wdata;
  sfpe_addr_t waddr, eaddr;
  sfpe_addr_t wa_q [$];
  logic [7:0] wd_q [$];
  int         error_cnt, num_checks, ecnt, bcnt;
  // line 1 is shared: the device wins while it drives
  assign din = {hd[3:2], oe[1] ? dout[1] : hd[1], hd[0]};
  sfpe_host u_host (.o_sck(sck), .o_cs_n(cs_n), .o_data(hd), .i_line1(din[1]));
  // short cycle counts keep the run brief
  sfpe_top #(.TPP_CYC(TPP), .TSE_CYC(TSE)) u_dut (
    .I_CLK(clk), .I_SRST(srst), .I_SCK(sck), .I_CS_N(cs_n), .I_DATA_LINE(din),
    .O_DATA_LINE(dout), .O_DATA_LINE_OE(oe), .I_FOUR_LINE_ENABLE(qen),
    .I_ADDR_4BYTE(a4), .I_PROTECT_BITS(bp), .O_BUSY_FLAG(busy),
    .O_WRITE_UNLOCK_LATCH(latch), .O_ARRAY_WE(we), .O_ARRAY_ADDR(waddr),
    .O_ARRAY_DATA(wdata), .O_ERASE_REQ(ereq), .O_ERASE_ADDR(eaddr), .O_ERASE_LOG2(elog2));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // capture array writes, erase requests and busy length
  always @(posedge clk) begin
    if (we === 1'b1) begin
      wa_q.push_back(waddr);
      wd_q.push_back(wdata);
    end
    if (ereq === 1'b1) ecnt++;
    if (busy === 1'b1) bcnt++;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // frame end is seen through a synchroniser, so allow a few cycles
  task automatic send(input int hdr, input bit q, input int extra);
    wa_q.delete();
    wd_q.delete();
    ecnt = 0;
    bcnt = 0;
    u_host.frame(hdr, q, extra);
    repeat (4) @(posedge clk);
    #2;
  endtask
  task automatic unlock();
    u_host.buf_q = {8'h06};
    send(1, 1'b0, 0);
    chk("latch", 32'h1, latch);
  endtask
  task automatic idle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim) begin
      @(posedge clk);
      #2;
      n++;
    end
    if (busy !== 1'b0) begin
      chk("idle timeout", 32'h0, 32'h1);
      test_done();
    end
  endtask
  // a refused frame starts nothing and writes nothing
  task automatic none(input int hdr, input bit q, input int extra);
    send(hdr, q, extra);
    chk("busy", 32'h0, busy);
    chk("writes", 32'h0, wa_q.size() + ecnt);
  endtask
  task automatic t_locked();
    u_host.buf_q = {8'h02, 8'h00, 8'h01, 8'h00, 8'haa};
    none(4, 1'b0, 0);
    unlock();
    u_host.buf_q = {8'h04};
    send(1, 1'b0, 0);
    chk("latch", 32'h0, latch);
    u_host.buf_q = {8'h02, 8'h00, 8'h01, 8'h00, 8'haa};
    none(4, 1'b0, 0);
    $display("end locked");
  endtask
  task automatic t_wrap();
    logic [31:0] ea [3];
    logic [7:0]  ed [3];
    ea = '{32'h1200, 32'h12fe, 32'h12ff};
    ed = '{8'h33, 8'h11, 8'h22};
    unlock();
    u_host.buf_q = {8'h02, 8'h00, 8'h12, 8'hfe, 8'h11, 8'h22, 8'h33};
    send(4, 1'b0, 0);
    chk("busy", 32'h1, busy);
    u_host.buf_q = {8'h05, 8'h00};
    u_host.frame(2, 1'b0, 0);
    chk("status", 32'h1, u_host.rx_q);
    idle(400);
    chk("latch", 32'h0, latch);
    chk("busy len", 32'h1, bcnt >= TPP + 256 && bcnt <= TPP + 260);
    chk("writes", 32'h3, wa_q.size());
    for (int i = 0; i < 3; i++) begin
      chk("addr", ea[i], wa_q[i]);
      chk("data", ed[i], wd_q[i]);
    end
    $display("end wrap");
  endtask
  task automatic t_over();
    int j;
    unlock();
    u_host.buf_q = {8'h02, 8'h00, 8'h40, 8'h00};
    for (int i = 0; i < 258; i++) u_host.buf_q.push_back(8'(i / 2));
    send(4, 1'b0, 0);
    idle(400);
    chk("writes", 32'd256, wa_q.size());
    for (int o = 0; o < 256; o++) begin
      j = (o < 2) ? o + 256 : o;
      chk("addr", 32'h4000 + o, wa_q[o]);
      chk("data", j / 2, wd_q[o]);
    end
    $display("end overflow");
  endtask
  task automatic t_erase();
    logic [7:0] op [3];
    logic [4:0] lg [3];
    op = '{8'h20, 8'h52, 8'hd8};
    lg = '{5'h0c, 5'h0f, 5'h10};
    for (int k = 0; k < 3; k++) begin
      unlock();
      u_host.buf_q = {op[k], 8'h12, 8'h34, 8'h56};
      send(4, 1'b0, 0);
      idle(200);
      chk("erase req", 32'h1, ecnt);
      chk("erase addr", 32'h123456 & ~((32'h1 << lg[k]) - 1), eaddr);
      chk("erase size", lg[k], elog2);
      chk("erase len", 32'h1, bcnt >= TSE && bcnt <= TSE + 4);
      chk("latch", 32'h0, latch);
    end
    // four-byte mode: mode is taken with the opcode, so set it between frames
    @(posedge clk);
    #2 a4 = 1'b1;
    unlock();
    u_host.buf_q = {8'h20, 8'h01, 8'h12, 8'h34, 8'h56};
    send(5, 1'b0, 0);
    idle(200);
    chk("erase req", 32'h1, ecnt);
    chk("erase addr", 32'h01123000, eaddr);
    @(posedge clk);
    #2 a4 = 1'b0;
    $display("end erase");
  endtask
  // one unlock serves every refusal, since refused frames leave the latch
  task automatic t_refuse();
    unlock();
    u_host.buf_q = {8'h02, 8'h00, 8'h50, 8'h00, 8'h77};
    none(4, 1'b0, 3);
    u_host.buf_q = {8'h20, 8'h00, 8'h50, 8'h00};
    none(4, 1'b0, 4);
    @(posedge clk);
    #2 bp = 5'h11;
    u_host.buf_q = {8'hd8, 8'h00, 8'h80, 8'h00};
    none(4, 1'b0, 0);
    u_host.buf_q = {8'h02, 8'h00, 8'h00, 8'h10, 8'h77};
    none(4, 1'b0, 0);
    @(posedge clk);
    #2 bp = 5'h00;
    u_host.buf_q = {8'h32, 8'h00, 8'h03, 8'h00, 8'h5c};
    none(4, 1'b1, 0);
    @(posedge clk);
    #2 qen = 1'b1;
    send(4, 1'b1, 0);
    idle(400);
    chk("writes", 32'h1, wa_q.size());
    chk("addr", 32'h300, wa_q[0]);
    chk("data", 32'h5c, wd_q[0]);
    $display("end refuse");
  endtask
  initial begin
    srst = 1'b1;
    qen = 1'b0;
    a4 = 1'b0;
    bp = 5'h00;
    error_cnt = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    #2 srst = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    chk("reset busy", 32'h0, busy);
    chk("reset latch", 32'h0, latch);
    t_locked();
    t_wrap();
    t_over();
    t_erase();
    t_refuse();
    test_done();
  end
endmodule
`default_nettype wire

// ---- bench/sfpe_host.sv ----
// host serial controller model: select, link clock and data lines
`timescale 1ns/1ps
`default_nettype none
// ========
// host model
module sfpe_host (
  output logic       o_sck,
  output logic       o_cs_n,
  output logic [3:0] o_data,
  input  wire logic  i_line1
);
  logic [7:0] buf_q [$];
  logic [7:0] rx_q;
  // link clock stands low and select high between frames
  // a real rise of select clears the link counters before the first frame
  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b0;
    o_data = 4'h0;
    rx_q   = 8'h00;
    #1 o_cs_n = 1'b1;
  end
  // one 48 ns link period, status line sampled on the rise
  task automatic tick(input logic [3:0] v);
    o_data = v;
    #24 o_sck = 1'b1;
    rx_q = {rx_q[6:0], i_line1};
    #24 o_sck = 1'b0;
  endtask
  // header bytes on one line, the rest as nibbles when q, then stray bits
  task automatic frame(input int hdr, input bit q, input int extra);
    o_cs_n = 1'b0; // low for the whole command
    #24;
    foreach (buf_q[i]) begin
      if (q && i >= hdr) begin
        tick(buf_q[i][7:4]); // high nibble first
        tick(buf_q[i][3:0]);
      end else begin
        for (int b = 7; b >= 0; b--) tick({3'b000, buf_q[i][b]}); // msb first
      end
    end
    repeat (extra) tick(4'h1);
    #24 o_cs_n = 1'b1;
    o_data = ~o_data; // released lines must not keep a stale value
    #200;
  endtask
endmodule
`default_nettype wire

// ---- src/sfpe_consts.svh ----
// constants of the serial flash program and erase sequencer
`ifndef SFPE_CONSTS_SVH
`define SFPE_CONSTS_SVH
// opcodes taken from the serial line
`define SFPE_OP_UNLOCK     8'h06
`define SFPE_OP_LOCK       8'h04
`define SFPE_OP_STATUS     8'h05
`define SFPE_OP_PAGE       8'h02
`define SFPE_OP_QPAGE      8'h32
`define SFPE_OP_SECTOR     8'h20
`define SFPE_OP_BLK32      8'h52
`define SFPE_OP_BLK64      8'hd8
// address lengths in bytes, and the count at which the header byte counter stops
`define SFPE_ALEN3         3'h3
`define SFPE_ALEN4         3'h4
`define SFPE_HDR_SAT       3'h7
// region sizes as log2 of bytes
`define SFPE_PAGE_LOG2     5'h08
`define SFPE_SECTOR_LOG2   5'h0c
`define SFPE_BLK32_LOG2    5'h0f
`define SFPE_BLK64_LOG2    5'h10
`define SFPE_PROT_LOG2     5'h10
`define SFPE_MEM_LOG2      25
// status byte bit positions
`define SFPE_STAT_BUSY     0
`define SFPE_STAT_UNLOCK   1
// timing, times in microseconds and clock rate in MHz
`define SFPE_CLK_MHZ       25
`define SFPE_TPP_US        1000
`define SFPE_TSE_US        50000
// one-hot sequencer state codes
`define SFPE_ST_IDLE       4'h1
`define SFPE_ST_PROG       4'h2
`define SFPE_ST_ERASE      4'h4
`define SFPE_ST_WAIT       4'h8
`endif

// ---- src/sfpe_cycle_timer.sv ----
// countdown timer for the self-timed program and erase cycles
`timescale 1ns/1ps
`default_nettype none
module sfpe_cycle_timer #(
  parameter int W = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_count,
  output logic              o_done
);
  logic [W-1:0] left_q;
  logic         run_q;
  // done is high on the cycle count cycles after the start
  assign o_done = run_q && (left_q == W'(1));
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      left_q <= '0;
      run_q  <= 1'b0;
    end else if (i_start) begin
      left_q <= i_count;
      run_q  <= 1'b1;
    end else if (run_q) begin
      left_q <= left_q - W'(1);
      run_q  <= !o_done;
    end
  end
endmodule
`default_nettype wire

// ---- src/sfpe_pkg.sv ----
// types of the serial flash program and erase sequencer
`include "sfpe_consts.svh"
package sfpe_pkg;
  typedef enum logic [3:0] {
    SFPE_IDLE  = `SFPE_ST_IDLE,
    SFPE_PROG  = `SFPE_ST_PROG,
    SFPE_ERASE = `SFPE_ST_ERASE,
    SFPE_WAIT  = `SFPE_ST_WAIT
  } sfpe_state_e;
  typedef logic [31:0] sfpe_addr_t;
endpackage

// ---- src/sfpe_sync.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sfpe_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_d,
  output logic [W-1:0]      o_q
);
  logic [W-1:0] meta_q;
  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= RST_VAL;
      o_q    <= RST_VAL;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- src/sfpe_top.sv ----
// serial flash program and erase sequencer: link receiver and self-timed cycles
`timescale 1ns/1ps
`default_nettype none
`include "sfpe_consts.svh"
// Notes on behaviour
// RL1: program and erase need the unlock latch set
// RL2: host sends 02h, address, data on one line
// RL3: data past page end wraps to offset zero
// RL4: beyond 256 bytes only the last 256 stay
// RL5: only addressed bytes of the page are written
// RL6: program frame must end on byte boundary
// RL7: host holds select low for whole command
// RL8: select rise starts timed page program cycle
// RL9: busy flag high for whole cycle, then low
// RL10: unlock latch clears before cycle ends
// RL11: program into protected page is ignored
// RL12: quad program 32h needs four-line enable
// RL13: host sends quad data on four lines
// RL14: sector erase 20h wipes the containing sector
// RL15: erase frame must end after address byte
// RL16: 52h wipes the containing 32KB block
// RL17: d8h wipes the containing 64KB block
// RL18: erase starts timed cycle of erase time
// RL19: erase of protected region is ignored
// RL20: address is 24 bits, 32 in four-byte mode
// RL21: status reads answered during busy cycles
// RL22: locked commands start nothing, busy stays low
module sfpe_top import sfpe_pkg::*; #(
  parameter int unsigned CLK_MHZ  = `SFPE_CLK_MHZ,
  parameter int unsigned TPP_US   = `SFPE_TPP_US,
  parameter int unsigned TSE_US   = `SFPE_TSE_US,
  parameter int unsigned TPP_CYC  = TPP_US * CLK_MHZ,
  parameter int unsigned TSE_CYC  = TSE_US * CLK_MHZ,
  parameter int          MEM_LOG2 = `SFPE_MEM_LOG2
) (
  input  wire logic       I_CLK,
  input  wire logic       I_SRST,
  input  wire logic       I_SCK,
  input  wire logic       I_CS_N,
  input  wire logic [3:0] I_DATA_LINE,
  output logic [3:0]      O_DATA_LINE,
  output logic [3:0]      O_DATA_LINE_OE,
  input  wire logic       I_FOUR_LINE_ENABLE,
  input  wire logic       I_ADDR_4BYTE,
  input  wire logic [4:0] I_PROTECT_BITS,
  output logic            O_BUSY_FLAG,
  output logic            O_WRITE_UNLOCK_LATCH,
  output logic            O_ARRAY_WE,
  output sfpe_addr_t      O_ARRAY_ADDR,
  output logic [7:0]      O_ARRAY_DATA,
  output logic            O_ERASE_REQ,
  output sfpe_addr_t      O_ERASE_ADDR,
  output logic [4:0]      O_ERASE_LOG2
);
  // =====================================================================
  // shared helpers
  function automatic sfpe_addr_t align_down(input sfpe_addr_t a, input logic [4:0] lg);
    return a & ~((32'h1 << lg) - 32'h1);
  endfunction

  // protected span grows from 64KB upward, at the top or (bit 4) the bottom
  function automatic logic hits_protect(input sfpe_addr_t a, input logic [4:0] lg,
                                        input logic [4:0] bp);
    logic [32:0] mem;
    logic [32:0] span;
    logic [32:0] lo;
    logic [32:0] hi;
    mem  = 33'h1 << MEM_LOG2;
    span = 33'h1 << (`SFPE_PROT_LOG2 + {1'b0, bp[3:0]} - 5'h01);
    if (span > mem) span = mem;
    lo = {1'b0, align_down(a, lg)};
    hi = lo + (33'h1 << lg);
    if (bp[3:0] == 4'h0) return 1'b0;
    return bp[4] ? (lo < span) : (hi > mem - span);
  endfunction

  // =====================================================================
  // link domain: shifting in on the serial clock
  logic [3:0] lk_s;          // busy, unlock, quad enable, four-byte mode
  logic       busy_s;
  logic       wel_s;
  logic       qe_s;
  logic       a4_s;
  logic [2:0] bit_q;
  logic [2:0] hdr_q;
  logic       nib_q;
  logic [7:0] sh_q;
  logic [7:0] opcode_q;
  logic [2:0] alen_q;
  logic       quad_q;
  logic       op_done_q;
  logic       addr_done_q;
  logic       data_seen_q;
  logic       mid_q;
  sfpe_addr_t addr_q;
  logic [7:0] ptr_q;
  logic [7:0] page_mem_q [0:255];
  logic [255:0] mask_q;
  logic       stat_bit_q;

  // configuration levels and status cross into the link clock
  sfpe_sync #(.W(4), .RST_VAL(4'h0)) u_lk_sync (
    .i_clk  (I_SCK),
    .i_srst (1'b0),
    .i_d    ({O_BUSY_FLAG, O_WRITE_UNLOCK_LATCH, I_FOUR_LINE_ENABLE, I_ADDR_4BYTE}),
    .o_q    (lk_s)
  );
  assign {busy_s, wel_s, qe_s, a4_s} = lk_s;

  logic       start;
  logic       in_data;
  logic       quad_data;
  logic       unit_done;
  logic [7:0] byte_in;
  logic       fill_ok;
  logic [7:0] stat_byte;
  assign start     = (hdr_q == 3'h0) && (bit_q == 3'h0);
  assign in_data   = (hdr_q != 3'h0) && (hdr_q > alen_q);
  assign quad_data = in_data && quad_q;                          // [RL12]
  assign unit_done = quad_data ? nib_q : (bit_q == 3'h7);
  assign byte_in   = quad_data ? {sh_q[3:0], I_DATA_LINE} : {sh_q[6:0], I_DATA_LINE[0]};
  // buffer frozen while a cycle reads it; a frame needs many edges to get here
  assign fill_ok   = !busy_s && ((opcode_q == `SFPE_OP_PAGE) || quad_q);
  assign stat_byte = {6'h00, wel_s, busy_s};

  // bit and byte counters restart whenever select is high
  always_ff @(posedge I_SCK or posedge I_CS_N) begin
    if (I_CS_N) begin
      bit_q <= 3'h0;
      hdr_q <= 3'h0;
      nib_q <= 1'b0;
    end else begin
      if (quad_data) begin
        nib_q <= ~nib_q;
      end else begin
        bit_q <= bit_q + 3'h1;
      end
      if (unit_done && (hdr_q != `SFPE_HDR_SAT)) begin
        hdr_q <= hdr_q + 3'h1;
      end
    end
  end

  // frame content survives select high so the core can read it afterwards
  always_ff @(posedge I_SCK) begin
    sh_q  <= byte_in;
    mid_q <= !unit_done;                                         // [RL6] [RL15]
    if (start) begin
      op_done_q   <= 1'b0;
      addr_done_q <= 1'b0;
      data_seen_q <= 1'b0;
      addr_q      <= '0;
    end
    if (unit_done) begin
      if (hdr_q == 3'h0) begin
        opcode_q  <= byte_in;
        op_done_q <= 1'b1;
        quad_q    <= (byte_in == `SFPE_OP_QPAGE) && qe_s;        // [RL12]
        alen_q    <= a4_s ? `SFPE_ALEN4 : `SFPE_ALEN3;           // [RL20]
      end else if (!in_data) begin
        addr_q <= {addr_q[23:0], byte_in};                       // [RL20]
        if (hdr_q == alen_q) begin
          addr_done_q <= 1'b1;
          ptr_q       <= byte_in;
        end
      end else begin
        data_seen_q <= 1'b1;
        ptr_q       <= ptr_q + 8'h01;                            // [RL3] [RL4]
      end
    end
  end

  // page buffer: wrapping pointer keeps the last 256 bytes in the page
  always_ff @(posedge I_SCK) begin
    if (unit_done && in_data && fill_ok) begin
      page_mem_q[ptr_q] <= byte_in;                              // [RL4]
    end
  end

  // written-byte mask, cleared at the first edge of each frame
  always_ff @(posedge I_SCK) begin
    if (start) begin
      mask_q <= '0;
    end else if (unit_done && in_data && fill_ok) begin
      mask_q[ptr_q] <= 1'b1;                                     // [RL5]
    end
  end

  // status byte shifted out msb first on the falling edge, repeating
  always_ff @(negedge I_SCK or posedge I_CS_N) begin
    if (I_CS_N) begin
      stat_bit_q <= 1'b0;
    end else begin
      stat_bit_q <= stat_byte[3'h7 - bit_q];                     // [RL21]
    end
  end

  logic stat_on;
  assign stat_on        = (hdr_q != 3'h0) && (opcode_q == `SFPE_OP_STATUS);
  assign O_DATA_LINE    = {2'b00, stat_bit_q, 1'b0};
  assign O_DATA_LINE_OE = {2'b00, stat_on, 1'b0};                // [RL21]

  // =====================================================================
  // core domain: frame end decode
  logic cs_s;
  logic cs_prev_q;
  logic frame_end;
  sfpe_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
    .i_clk  (I_CLK),
    .i_srst (I_SRST),
    .i_d    (I_CS_N),
    .o_q    (cs_s)
  );
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= cs_s;
    end
  end
  assign frame_end = cs_s && !cs_prev_q;

  sfpe_state_e state_q;
  logic        wel_q;
  logic        aligned;
  logic        op_prog;
  logic        op_erase;
  logic [4:0]  erase_lg;
  logic        prog_ok;
  logic        erase_ok;
  assign aligned  = op_done_q && !mid_q;                         // [RL6] [RL15]
  assign op_prog  = (opcode_q == `SFPE_OP_PAGE) ||
                    ((opcode_q == `SFPE_OP_QPAGE) && quad_q);    // [RL12]
  assign op_erase = (opcode_q == `SFPE_OP_SECTOR) || (opcode_q == `SFPE_OP_BLK32) ||
                    (opcode_q == `SFPE_OP_BLK64);
  // erase size from opcode
  always_comb begin
    unique case (opcode_q)
      `SFPE_OP_BLK32: erase_lg = `SFPE_BLK32_LOG2;               // [RL16]
      `SFPE_OP_BLK64: erase_lg = `SFPE_BLK64_LOG2;               // [RL17]
      default:        erase_lg = `SFPE_SECTOR_LOG2;              // [RL14]
    endcase
  end
  // unlock latch, complete header, boundary and protection all required
  assign prog_ok  = wel_q && aligned && op_prog && addr_done_q && data_seen_q &&
                    !hits_protect(addr_q, `SFPE_PAGE_LOG2, I_PROTECT_BITS);  // [RL1] [RL11]
  assign erase_ok = wel_q && aligned && op_erase && addr_done_q && !data_seen_q &&
                    !hits_protect(addr_q, erase_lg, I_PROTECT_BITS);         // [RL15] [RL19]

  logic accept;
  assign accept = frame_end && (state_q == SFPE_IDLE) && (prog_ok || erase_ok);

  // =====================================================================
  // core domain: sequencer
  logic [7:0]   idx_q;
  logic [255:0] mask_cap_q;
  sfpe_addr_t   page_q;
  logic         tmr_start;
  logic [31:0]  tmr_count;
  logic         tmr_done;
  assign tmr_start = ((state_q == SFPE_PROG) && (idx_q == 8'hff)) || (state_q == SFPE_ERASE);
  assign tmr_count = (state_q == SFPE_ERASE) ? 32'(TSE_CYC) : 32'(TPP_CYC);  // [RL8] [RL18]

  sfpe_cycle_timer #(.W(32)) u_timer (
    .i_clk   (I_CLK),
    .i_srst  (I_SRST),
    .i_start (tmr_start),
    .i_count (tmr_count),
    .o_done  (tmr_done)
  );

  // state walk: idle, stream page or issue erase, then timed wait
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      state_q <= SFPE_IDLE;
    end else begin
      unique case (state_q)
        SFPE_IDLE: begin
          if (accept) begin
            state_q <= prog_ok ? SFPE_PROG : SFPE_ERASE;         // [RL8] [RL18]
          end
        end
        SFPE_PROG: begin
          if (idx_q == 8'hff) begin
            state_q <= SFPE_WAIT;
          end
        end
        SFPE_ERASE: state_q <= SFPE_WAIT;
        SFPE_WAIT: begin
          if (tmr_done) begin
            state_q <= SFPE_IDLE;                                // [RL9]
          end
        end
        default: state_q <= SFPE_IDLE;
      endcase
    end
  end
  assign O_BUSY_FLAG = (state_q != SFPE_IDLE);                   // [RL9] [RL22]

  // capture mask and target at acceptance; the next frame may clear the link copy
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      idx_q      <= 8'h00;
      mask_cap_q <= '0;
      page_q     <= '0;
    end else begin
      if (accept) begin
        idx_q      <= 8'h00;
        mask_cap_q <= mask_q;
        page_q     <= addr_q;
      end else if (state_q == SFPE_PROG) begin
        idx_q <= idx_q + 8'h01;
      end
    end
  end

  // unlock latch: cleared as a cycle starts, long before it ends
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      wel_q <= 1'b0;
    end else if (frame_end && (state_q == SFPE_IDLE) && aligned) begin
      if (prog_ok || erase_ok) begin
        wel_q <= 1'b0;                                           // [RL10]
      end else if (opcode_q == `SFPE_OP_UNLOCK) begin
        wel_q <= 1'b1;                                           // [RL1]
      end else if (opcode_q == `SFPE_OP_LOCK) begin
        wel_q <= 1'b0;
      end
    end
  end
  assign O_WRITE_UNLOCK_LATCH = wel_q;

  // array write port: only bytes the host actually sent
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_ARRAY_WE   <= 1'b0;
      O_ARRAY_ADDR <= '0;
      O_ARRAY_DATA <= 8'h00;
    end else begin
      O_ARRAY_WE   <= (state_q == SFPE_PROG) && mask_cap_q[idx_q];   // [RL5]
      O_ARRAY_ADDR <= {page_q[31:8], idx_q};                          // [RL3]
      O_ARRAY_DATA <= page_mem_q[idx_q];
    end
  end

  // erase request: base of the region that holds the address
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_ERASE_REQ  <= 1'b0;
      O_ERASE_ADDR <= '0;
      O_ERASE_LOG2 <= 5'h00;
    end else begin
      O_ERASE_REQ <= accept && !prog_ok;
      if (accept && !prog_ok) begin
        O_ERASE_ADDR <= align_down(addr_q, erase_lg);            // [RL14] [RL16] [RL17]
        O_ERASE_LOG2 <= erase_lg;
      end
    end
  end

  // =====================================================================
  // checks
  logic [31:0] wait_cnt_q;
  logic [31:0] wait_len_q;
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      wait_cnt_q <= '0;
      wait_len_q <= '0;
    end else begin
      wait_cnt_q <= (state_q == SFPE_WAIT) ? wait_cnt_q + 32'h1 : 32'h0;
      if (tmr_start) begin
        wait_len_q <= tmr_count;
      end
    end
  end

  sequence s_prog_accept;
    frame_end && (state_q == SFPE_IDLE) && prog_ok;
  endsequence
  sequence s_stream;
    (state_q == SFPE_PROG && O_BUSY_FLAG) [*8];
  endsequence

  a_prog_busy: assert property (@(posedge I_CLK) disable iff (I_SRST)  // [RL9]
    s_prog_accept |=> s_stream) else $error("program accept did not hold busy");
  a_locked_idle: assert property (@(posedge I_CLK) disable iff (I_SRST)  // [RL22]
    (frame_end && !wel_q && !O_BUSY_FLAG) |=> !O_BUSY_FLAG)
    else $error("locked command started a cycle");
  a_busy_cause: assert property (@(posedge I_CLK) disable iff (I_SRST)  // [RL8]
    $rose(O_BUSY_FLAG) |-> $past(frame_end) && $past(wel_q))
    else $error("busy rose without an unlocked frame end");
  a_latch_drop: assert property (@(posedge I_CLK) disable iff (I_SRST)  // [RL10]
    $rose(O_BUSY_FLAG) |-> !O_WRITE_UNLOCK_LATCH) else $error("latch still set in cycle");
  a_cycle_len: assert property (@(posedge I_CLK) disable iff (I_SRST)  // [RL18]
    (state_q == SFPE_WAIT && tmr_done) |-> (wait_cnt_q + 32'h1 == wait_len_q))
    else $error("timed cycle length wrong");
  a_quad_gate: assert property (@(posedge I_CLK) disable iff (I_SRST)  // [RL12]
    (frame_end && opcode_q == `SFPE_OP_QPAGE && !quad_q && !O_BUSY_FLAG) |=> !O_BUSY_FLAG)
    else $error("quad program ran without four-line enable");
  a_misaligned: assert property (@(posedge I_CLK) disable iff (I_SRST)  // [RL6]
    (frame_end && mid_q && !O_BUSY_FLAG) |=> !O_BUSY_FLAG)
    else $error("partial byte frame was executed");
  a_page_stay: assert property (@(posedge I_CLK) disable iff (I_SRST)  // [RL3]
    O_ARRAY_WE |-> (O_ARRAY_ADDR[31:8] == page_q[31:8]) && $past(mask_cap_q[idx_q]))
    else $error("write left the page or hit an unsent byte");
  a_prog_protect: assert property (@(posedge I_CLK) disable iff (I_SRST)  // [RL11]
    $rose(O_ARRAY_WE) |-> !hits_protect(O_ARRAY_ADDR, `SFPE_PAGE_LOG2, $past(I_PROTECT_BITS, 2)))
    else $error("program wrote a protected page");
  a_erase_align: assert property (@(posedge I_CLK) disable iff (I_SRST)  // [RL14]
    O_ERASE_REQ |-> (O_ERASE_ADDR == align_down(O_ERASE_ADDR, O_ERASE_LOG2)) &&
                    (O_ERASE_LOG2 inside {`SFPE_SECTOR_LOG2, `SFPE_BLK32_LOG2, `SFPE_BLK64_LOG2})
                    ##1 O_BUSY_FLAG)
    else $error("erase base not aligned");
  a_erase_protect: assert property (@(posedge I_CLK) disable iff (I_SRST)  // [RL19]
    O_ERASE_REQ |-> !hits_protect(O_ERASE_ADDR, O_ERASE_LOG2, $past(I_PROTECT_BITS)))
    else $error("erase hit a protected region");
endmodule
`default_nettype wire
